//--- pdfp_defines.svh
// Register offsets, field positions and reset values for the post dividers
`ifndef PDFP_DEFINES_SVH
`define PDFP_DEFINES_SVH
`define PDFP_ADDR_W          8
`define PDFP_REG_W           24
`define PDFP_OFF_S0D         8'h89
`define PDFP_OFF_S1A         8'h8c
`define PDFP_OFF_S1B         8'h8f
`define PDFP_OFF_S1C         8'h92
`define PDFP_RST_S0D         24'h00_0040
`define PDFP_RST_S1A         24'h00_0002
`define PDFP_RST_S1B         24'h00_0002
`define PDFP_RST_S1C         24'h00_0032
`define PDFP_SHAPE_HI        23
`define PDFP_SHAPE_LO        20
`define PDFP_SHAPE_FRAME     4'hf
`define PDFP_TYPE_BIT        19
`define PDFP_POL_BIT         18
`define PDFP_SEL_HI          17
`define PDFP_SEL_LO          16
`define PDFP_PERIOD_HI       15
`define PDFP_PERIOD_LO       0
`define PDFP_RATIO_HI        22
`define PDFP_RATIO_LO        0
`define PDFP_RSVD_BIT        23
`endif

//--- pdfp_pkg.sv
// Types shared by the post divider block
package pdfp_pkg;
  typedef enum logic [1:0] {
    PDFP_REL_A,
    PDFP_REL_B,
    PDFP_REL_C,
    PDFP_REL_RSVD
  } pdfp_rel_sel_t;
  typedef enum logic {
    PDFP_MODE_CLOCK,
    PDFP_MODE_FRAME
  } pdfp_mode_t;
endpackage

//--- pdfp_div.sv
// Integer clock divider, 50 percent duty for even ratios; odd ratios give the high phase the larger half
`timescale 1ns/1ps
module pdfp_div (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // Control
  input  wire logic [23:0] ratio_in,
  // Divided clock
  output logic             clk_out,
  output logic             rise_out
);
  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  logic        lvl_q;
  logic        lvl_d;
  logic [23:0] high_len;
  logic [23:0] last_cnt;

  // High phase is the larger half so odd ratios stay near 50 percent
  always_comb begin
    high_len = ratio_in - (ratio_in >> 1);
    last_cnt = ratio_in - 24'h00_0001;
    cnt_d    = cnt_q + 24'h00_0001;
    lvl_d    = lvl_q;
    // Ratios 0 and 1 pass no divided clock; hold low
    if (ratio_in < 24'h00_0002) begin
      cnt_d = 24'h00_0000;
      lvl_d = 1'b0;
    end else if (cnt_q >= last_cnt) begin
      cnt_d = 24'h00_0000;
      lvl_d = 1'b1;
    end else if (cnt_q + 24'h00_0001 == high_len) begin
      lvl_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_q <= 24'h00_0000;
      lvl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  assign clk_out  = lvl_q;
  assign rise_out = lvl_d & ~lvl_q;
endmodule

//--- pdfp_top.sv
// Post divider registers, divided clocks and synthesizer 0 frame pulse output
// Behaviour
// - Shape field all ones makes divider D emit a frame pulse.
// - Other shape values give a clock, 50% for even ratios (odd: high the larger half), VCO over full 24-bit ratio.
// - Related select 00/01/10 picks A/B/C; pulse one related period wide.
// - Polarity bit clear gives normal pulse, set gives inverted pulse.
// - Type bit clear centres boundary in pulse; set puts it on edge.
// - Low sixteen bits count related periods between frame pulses.
// - Synth 1 divided by 23-bit ratio A; top bit kept zero.
// - Synth 1 divided by 23-bit ratio B; top bit kept zero.
`timescale 1ns/1ps
`include "pdfp_defines.svh"
module pdfp_top (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  // Register port
  input  wire logic [`PDFP_ADDR_W-1:0] reg_addr_in,
  input  wire logic                   reg_wr_in,
  input  wire logic [`PDFP_REG_W-1:0] reg_wdata_in,
  output logic      [`PDFP_REG_W-1:0] reg_rdata_out,
  // Synthesizer 0 related clocks, as divided elsewhere
  input  wire logic                   synth0_clk_a_in,
  input  wire logic                   synth0_clk_b_in,
  input  wire logic                   synth0_clk_c_in,
  // Divided outputs and frame mode flag
  output logic                        first_synth_ratio_d_out,
  output logic                        second_synth_ratio_a_out,
  output logic                        second_synth_ratio_b_out,
  output logic                        frame_mode_out
);
  logic [23:0] s0d_q;
  logic [23:0] s0d_d;
  logic [23:0] s1a_q;
  logic [23:0] s1a_d;
  logic [23:0] s1b_q;
  logic [23:0] s1b_d;
  logic [23:0] s1c_q;
  logic [23:0] s1c_d;

  // Last related period of a frame; a zero period behaves as one
  function automatic logic period_end(input logic [15:0] cnt,
                                      input logic [15:0] len);
    logic [15:0] nxt;
    nxt = cnt + 16'h0001;
    return nxt >= len;
  endfunction

  // Register file
  always_comb begin
    s0d_d = s0d_q;
    s1a_d = s1a_q;
    s1b_d = s1b_q;
    s1c_d = s1c_q;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `PDFP_OFF_S0D: s0d_d = reg_wdata_in;
        `PDFP_OFF_S1A: s1a_d = reg_wdata_in;
        `PDFP_OFF_S1B: s1b_d = reg_wdata_in;
        `PDFP_OFF_S1C: s1c_d = reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s0d_q <= `PDFP_RST_S0D;
      s1a_q <= `PDFP_RST_S1A;
      s1b_q <= `PDFP_RST_S1B;
      s1c_q <= `PDFP_RST_S1C;
    end else begin
      s0d_q <= s0d_d;
      s1a_q <= s1a_d;
      s1b_q <= s1b_d;
      s1c_q <= s1c_d;
    end
  end

  // Unmapped reads return zero
  always_comb begin
    unique case (reg_addr_in)
      `PDFP_OFF_S0D: reg_rdata_out = s0d_q;
      `PDFP_OFF_S1A: reg_rdata_out = s1a_q;
      `PDFP_OFF_S1B: reg_rdata_out = s1b_q;
      `PDFP_OFF_S1C: reg_rdata_out = s1c_q;
      default:       reg_rdata_out = 24'h00_0000;
    endcase
  end

  // Mode decode
  pdfp_pkg::pdfp_mode_t    mode;
  pdfp_pkg::pdfp_rel_sel_t rel_sel;
  logic                    pol_inv;
  logic                    type_edge;
  logic [15:0]             period;

  always_comb begin
    mode = (s0d_q[`PDFP_SHAPE_HI:`PDFP_SHAPE_LO] == `PDFP_SHAPE_FRAME) ?
           pdfp_pkg::PDFP_MODE_FRAME : pdfp_pkg::PDFP_MODE_CLOCK;
    rel_sel   = pdfp_pkg::pdfp_rel_sel_t'(s0d_q[`PDFP_SEL_HI:`PDFP_SEL_LO]);
    pol_inv   = s0d_q[`PDFP_POL_BIT];
    type_edge = s0d_q[`PDFP_TYPE_BIT];
    period    = s0d_q[`PDFP_PERIOD_HI:`PDFP_PERIOD_LO];
  end

  // Plain dividers; ratio is the whole register in clock mode
  logic d_clk;
  pdfp_div u_div_d (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .ratio_in (s0d_q),
    .clk_out  (d_clk),
    .rise_out ()
  );

  // Reserved top bit is masked so a stray one cannot enlarge the ratio
  pdfp_div u_div_a (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .ratio_in ({1'b0, s1a_q[`PDFP_RATIO_HI:`PDFP_RATIO_LO]}),
    .clk_out  (second_synth_ratio_a_out),
    .rise_out ()
  );

  pdfp_div u_div_b (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .ratio_in ({1'b0, s1b_q[`PDFP_RATIO_HI:`PDFP_RATIO_LO]}),
    .clk_out  (second_synth_ratio_b_out),
    .rise_out ()
  );

  // Related clock selection; reserved code yields no reference
  logic rel_clk;
  always_comb begin
    unique case (rel_sel)
      pdfp_pkg::PDFP_REL_A:    rel_clk = synth0_clk_a_in;
      pdfp_pkg::PDFP_REL_B:    rel_clk = synth0_clk_b_in;
      pdfp_pkg::PDFP_REL_C:    rel_clk = synth0_clk_c_in;
      pdfp_pkg::PDFP_REL_RSVD: rel_clk = 1'b0;
    endcase
  end

  // Related clock sampled to find its edges
  logic                    rel_q;
  logic                    rel_d;
  logic [15:0]             pcnt_q;
  logic [15:0]             pcnt_d;
  logic                    pulse_q;
  logic                    pulse_d;
  logic                    rel_rise;
  logic                    rel_fall;
  // A new select would show the old clock's level as a false edge
  pdfp_pkg::pdfp_rel_sel_t sel_q;
  pdfp_pkg::pdfp_rel_sel_t sel_d;
  logic                    sel_chg;

  // Edge style pulse spans one full related period from a rising edge;
  // centred style starts half a period earlier, on the falling edge.
  always_comb begin
    rel_d    = rel_clk;
    sel_d    = rel_sel;
    sel_chg  = (rel_sel != sel_q);
    rel_rise = rel_clk & ~rel_q & ~sel_chg;
    rel_fall = ~rel_clk & rel_q & ~sel_chg;
    pcnt_d   = pcnt_q;
    pulse_d  = pulse_q;
    // Reserved select has no reference, so the pulse rests inactive
    if (mode == pdfp_pkg::PDFP_MODE_CLOCK ||
        rel_sel == pdfp_pkg::PDFP_REL_RSVD) begin
      pcnt_d  = 16'h0000;
      pulse_d = 1'b0;
    end else begin
      if (rel_rise) begin
        // Frame boundary on each wrap of the period count
        pcnt_d = period_end(pcnt_q, period) ? 16'h0000 :
                 pcnt_q + 16'h0001;
        if (type_edge) begin
          pulse_d = (pcnt_d == 16'h0000);
        end else if (pcnt_q == 16'h0000) begin
          pulse_d = 1'b0;
        end
      end
      if (rel_fall && !type_edge) begin
        // Centred pulse: high from the fall before the boundary
        if (period_end(pcnt_q, period)) begin
          pulse_d = 1'b1;
        end else if (pulse_q && pcnt_q == 16'h0000) begin
          pulse_d = 1'b0;
        end
      end
    end
  end

  logic out_d_q;
  logic out_d_d;
  always_comb begin
    if (mode == pdfp_pkg::PDFP_MODE_FRAME) begin
      out_d_d = pulse_q ^ pol_inv;
    end else begin
      out_d_d = d_clk;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rel_q   <= 1'b0;
      pcnt_q  <= 16'h0000;
      pulse_q <= 1'b0;
      out_d_q <= 1'b0;
      sel_q   <= pdfp_pkg::PDFP_REL_A;
    end else begin
      rel_q   <= rel_d;
      sel_q   <= sel_d;
      pcnt_q  <= pcnt_d;
      pulse_q <= pulse_d;
      out_d_q <= out_d_d;
    end
  end

  assign first_synth_ratio_d_out = out_d_q;
  assign frame_mode_out = (mode == pdfp_pkg::PDFP_MODE_FRAME);
endmodule

//--- pdfp_checker.sv
// Port assertions for the post divider block
`timescale 1ns/1ps
module pdfp_checker (
  // Clock, reset and register port
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic [23:0] reg_wdata_in,
  input wire logic [23:0] reg_rdata_out,
  // Clocks
  input wire logic        synth0_clk_a_in,
  input wire logic        synth0_clk_b_in,
  input wire logic        synth0_clk_c_in,
  input wire logic        first_synth_ratio_d_out,
  input wire logic        second_synth_ratio_a_out,
  input wire logic        second_synth_ratio_b_out,
  input wire logic        frame_mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_FRAME_ON: assert property (
    reg_wr_in && reg_addr_in == 8'h89 && &reg_wdata_in[23:20]
    |=> frame_mode_out) else $error("frame mode not entered");
  AST_FRAME_OFF: assert property (
    reg_wr_in && reg_addr_in == 8'h89 && !(&reg_wdata_in[23:20])
    |=> !frame_mode_out) else $error("frame mode not left");
  AST_MODE_DECODE: assert property (
    reg_addr_in == 8'h89 |-> frame_mode_out == (&reg_rdata_out[23:20]))
    else $error("frame mode disagrees with shape field");
  AST_MODE_HOLD: assert property (
    !$past(reg_wr_in) |-> $stable(frame_mode_out))
    else $error("frame mode moved without a write");
  AST_RB_D: assert property (
    reg_wr_in && reg_addr_in == 8'h89 |=> reg_addr_in != 8'h89 ||
    reg_rdata_out == $past(reg_wdata_in)) else $error("divider D lost");
  AST_RB_A: assert property (
    reg_wr_in && reg_addr_in == 8'h8c |=> reg_addr_in != 8'h8c ||
    reg_rdata_out == $past(reg_wdata_in)) else $error("divider A lost");
  AST_RB_B: assert property (
    reg_wr_in && reg_addr_in == 8'h8f |=> reg_addr_in != 8'h8f ||
    reg_rdata_out == $past(reg_wdata_in)) else $error("divider B lost");
  AST_RST_IDLE: assert property (
    $fell(reset_in) |-> !first_synth_ratio_d_out && !frame_mode_out &&
    !second_synth_ratio_a_out) else $error("outputs not idle at reset");
endmodule

//--- post_divider_frame_pulse_config_test.sv
// Self-checking bench for the post divider block
`timescale 1ns/1ps
module post_divider_frame_pulse_config_test;
  logic        clk_in = 1'h0;
  logic        reset_in = 1'h1;
  logic [7:0]  reg_addr_in = 8'h00;
  logic        reg_wr_in = 1'h0;
  logic [23:0] reg_wdata_in = 24'h00_0000;
  logic [23:0] reg_rdata_out;
  logic [4:0]  rc = 5'h00;
  logic        synth0_clk_a_in, synth0_clk_b_in, synth0_clk_c_in;
  logic        first_synth_ratio_d_out, frame_mode_out;
  logic        second_synth_ratio_a_out, second_synth_ratio_b_out;
  int          failures = 0;
  int          checks_done = 0;
  pdfp_top u_dut (.clk_in, .reset_in, .reg_addr_in, .reg_wr_in,
    .reg_wdata_in, .reg_rdata_out, .synth0_clk_a_in, .synth0_clk_b_in,
    .synth0_clk_c_in, .first_synth_ratio_d_out, .second_synth_ratio_a_out,
    .second_synth_ratio_b_out, .frame_mode_out);
  always #10 clk_in = ~clk_in;
  // Related clocks of periods 4, 6 and 8 share one 24 cycle counter
  always @(posedge clk_in) rc <= (rc == 5'h17) ? 5'h00 : rc + 5'h01;
  assign synth0_clk_a_in = ~rc[1];
  assign synth0_clk_b_in = (rc % 5'h06) < 5'h03;
  assign synth0_clk_c_in = ~rc[2];
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [23:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wr_in <= 1'h1;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
  endtask
  task automatic rd(logic [7:0] a, logic [23:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    @(negedge clk_in);
    chk("rdata", e, reg_rdata_out);
  endtask
  function automatic logic pick(int s);
    return s == 0 ? first_synth_ratio_d_out :
      s == 1 ? second_synth_ratio_a_out : second_synth_ratio_b_out;
  endfunction
  // Skip to a rising edge, then count the high run and the whole period
  task automatic meas(int s, logic inv, output int hi, output int per);
    int n;
    hi = 0;
    per = 0;
    n = 0;
    for (int ph = 0; ph < 4; ph++)
      while ((pick(s) ^ inv) !== ph[0] && n < 900) begin
        @(negedge clk_in);
        n++;
        per += int'(ph > 1);
        hi += int'(ph == 2);
      end
  endtask
  // First run is discarded as it may straddle a reprogramming
  task automatic wave(int s, logic inv, int e_hi, int e_per);
    int h, p;
    meas(s, inv, h, p);
    meas(s, inv, h, p);
    chk("high", 24'(e_hi), 24'(h));
    chk("period", 24'(e_per), 24'(p));
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'h0;
    rd(8'h89, 24'h00_0040);
    rd(8'h8c, 24'h00_0002);
    rd(8'h8f, 24'h00_0002);
    rd(8'h92, 24'h00_0032);
    rd(8'h8a, 24'h00_0000);
    wave(1, 1'h0, 1, 2);
    $display("test reset done");
    wr(8'h8c, 24'h00_0003);
    wr(8'h8f, 24'h00_0005);
    wr(8'h8a, 24'h00_0007);
    rd(8'h8a, 24'h00_0000);
    wave(1, 1'h0, 2, 3);
    wave(2, 1'h0, 3, 5);
    wr(8'h89, 24'h00_0006); // Small ratio, well under the limit
    wave(0, 1'h0, 3, 6);
    chk("mode", 24'h00_0000, 24'(frame_mode_out));
    $display("test dividers done");
    // Divider D never picks itself as reference
    for (int s = 0; s < 3; s++)
      for (int k = 0; k < 4; k++) begin
        wr(8'h89, {4'hf, k[1], k[0], s[1:0], 16'h0003});
        wave(0, k[0], 4 + 2 * s, 12 + 6 * s);
      end
    chk("mode", 24'h00_0001, 24'(frame_mode_out));
    wr(8'h89, 24'hf7_0003);
    repeat (40) @(posedge clk_in);
    chk("idle", 24'h00_0001, 24'(first_synth_ratio_d_out));
    $display("test frame pulse done");
    test_done;
  end
  initial begin
    #400000;
    failures++;
    test_done;
  end
endmodule
bind pdfp_top pdfp_checker u_chk (.clk_in, .reset_in, .reg_addr_in,
  .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .synth0_clk_a_in,
  .synth0_clk_b_in, .synth0_clk_c_in, .first_synth_ratio_d_out,
  .second_synth_ratio_a_out, .second_synth_ratio_b_out, .frame_mode_out);
